// File: rtl/uems_map.svh
`ifndef UEMS_MAP_SVH
`define UEMS_MAP_SVH
// extended configuration offsets of the block
`define UEMS_OFS_STATUS      12'h104
`define UEMS_OFS_HIDE        12'h108
`define UEMS_OFS_FATALITY    12'h10c
// implemented error positions, shared by all three registers
`define UEMS_IMPL_MASK       32'h001ff010
// field positions
`define UEMS_BIT_LINK_LAYER  4
`define UEMS_BIT_POISONED    12
`define UEMS_BIT_FLOW_CTRL   13
`define UEMS_BIT_CPL_TIMEOUT 14
`define UEMS_BIT_CPL_ABORT   15
`define UEMS_BIT_UNEXP_CPL   16
`define UEMS_BIT_RX_OVERRUN  17
`define UEMS_BIT_MALFORMED   18
`define UEMS_BIT_E2E_CRC     19
`define UEMS_BIT_UNSUP_REQ   20
// reset values
`define UEMS_RST_STATUS      32'h00000000
`define UEMS_RST_HIDE        32'h00000000
`define UEMS_RST_FATALITY    32'h00062011
// fatality bit 0 always reads as one
`define UEMS_FAT_FORCED      32'h00000001
// access answers one cycle after the request
`define UEMS_ACK_CYCLES      1
`endif

// File: rtl/uems_pkg.sv
package uems_pkg;
  // one bit per position of the 32-bit error word
  typedef logic [31:0] uems_word_t;
  // kind of error message leaving the block
  typedef enum logic [1:0] {
    UEMS_MSG_NONE     = 2'h0,
    UEMS_MSG_NONFATAL = 2'h1,
    UEMS_MSG_FATAL    = 2'h3
  } uems_msg_e;
endpackage

// File: rtl/uems_report.sv
`timescale 1ns/1ps
`default_nettype none
`include "uems_map.svh"
// status recording and message, header and pointer requests
module uems_report (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire uems_pkg::uems_word_t err_detect,
  input  wire uems_pkg::uems_word_t hide,
  input  wire uems_pkg::uems_word_t fatality,
  input  wire uems_pkg::uems_word_t status_clr,
  output var  uems_pkg::uems_word_t status_r,
  output var  uems_pkg::uems_msg_e  msg_kind_r,
  output var  logic                 hdr_load_r,
  output var  logic                 fep_load_r,
  output var  logic [4:0]           fep_r
);
  // lowest set position, used for the first error pointer
  function automatic logic [4:0] low_bit(input uems_pkg::uems_word_t v);
    logic [4:0] idx;
    idx = 5'h0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  uems_pkg::uems_word_t live;          // unmasked, implemented errors
  uems_pkg::uems_word_t status_nxt;
  uems_pkg::uems_msg_e  msg_kind_nxt;
  logic                 hdr_load_nxt;
  logic                 fep_load_nxt;
  logic [4:0]           fep_nxt;

  // next state of status and request strobes
  always_comb begin
    live         = err_detect & ~hide & `UEMS_IMPL_MASK;
    // set wins over a write-one clear in the same cycle
    status_nxt   = (status_r & ~status_clr) | live;
    msg_kind_nxt = uems_pkg::UEMS_MSG_NONE;
    hdr_load_nxt = 1'b0;
    fep_load_nxt = 1'b0;
    fep_nxt      = fep_r;
    if (live != 32'h0) begin
      // fatal dominates when several arrive together
      if ((live & fatality) != 32'h0) begin
        msg_kind_nxt = uems_pkg::UEMS_MSG_FATAL;
      end else begin
        msg_kind_nxt = uems_pkg::UEMS_MSG_NONFATAL;
      end
      hdr_load_nxt = 1'b1;
      // pointer moves only when no older error is pending
      if ((status_r & ~status_clr) == 32'h0) begin
        fep_load_nxt = 1'b1;
        fep_nxt      = low_bit(live);
      end
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r   <= `UEMS_RST_STATUS;
      msg_kind_r <= uems_pkg::UEMS_MSG_NONE;
      hdr_load_r <= 1'b0;
      fep_load_r <= 1'b0;
      fep_r      <= 5'h0;
    end else begin
      status_r   <= status_nxt;
      msg_kind_r <= msg_kind_nxt;
      hdr_load_r <= hdr_load_nxt;
      fep_load_r <= fep_load_nxt;
      fep_r      <= fep_nxt;
    end
  end
endmodule
`default_nettype wire

// File: rtl/uems_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uems_map.svh"
// How it works
// - masked error never sets its status bit
// - masked error sends no error message
// - masked error leaves header log untouched
// - masked error leaves first error pointer
// - hide register at 108h, resets zero
// - hide bits 19, 18, 17 writable
// - hide bits 16, 15, 14 writable
// - hide bits 13, 12, 4 writable
// - hide reserved bits read zero, ignore writes
// - fatality one means fatal, zero nonfatal
// - fatality register at 10Ch, resets 00062011h
// - malformed, overrun, flow, link default fatal
// - remaining error kinds default nonfatal
// - fatality bit zero always reads one
// - other fatality reserved bits read zero
// - each bit governs same status position
module uems_top #(
  parameter int ADDR_W = 12            // extended configuration space
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cfg_rd_req,
  input  wire logic              cfg_wr_req,
  input  wire logic [ADDR_W-1:0] cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  input  wire logic [31:0]       err_detect,
  output var  logic [31:0]       cfg_rdata_r,
  output var  logic              cfg_done_r,
  output var  logic [31:0]       status_r,
  output var  logic [31:0]       hide_r,
  output var  logic [31:0]       fatality_r,
  output var  logic              msg_valid_r,
  output var  logic              msg_fatal_r,
  output var  logic              hdr_load_r,
  output var  logic              fep_load_r,
  output var  logic [4:0]        fep_r
);
  // the address must reach the highest register offset
  if (ADDR_W < 9 || ADDR_W > 12) begin : g_addr_check
    $error("uems_top: ADDR_W must lie between 9 and 12");
  end

  // byte enables widened to a bit mask, used by all three register writes
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // merge a write into a register, only implemented bits move
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] lm);
    logic [31:0] wm;
    wm = lm & `UEMS_IMPL_MASK;
    return (old & ~wm) | (wd & wm);
  endfunction

  // address decode, compared on the full printed offset
  logic hit_status;                    // status word
  logic hit_hide;                      // mask word
  logic hit_fat;                       // severity word
  logic [11:0] addr12;                 // offset padded to 12 bits
  logic [31:0] lanes;                  // write bit mask

  always_comb begin
    addr12     = 12'(cfg_addr);
    hit_status = (addr12 == `UEMS_OFS_STATUS);
    hit_hide   = (addr12 == `UEMS_OFS_HIDE);
    hit_fat    = (addr12 == `UEMS_OFS_FATALITY);
    lanes      = lane_mask(cfg_be);
  end

  // --- control registers -------------------------------------------
  logic [31:0] hide_nxt;               // next mask word
  logic [31:0] fat_nxt;                // next severity word
  logic [31:0] status_clr;             // write-one clear pattern

  // writes touch only implemented positions; reserved ignore them
  always_comb begin
    hide_nxt   = hide_r;
    fat_nxt    = fatality_r;
    status_clr = 32'h0;
    if (cfg_wr_req) begin
      if (hit_hide) begin
        hide_nxt = merge(hide_r, cfg_wdata, lanes);
      end
      if (hit_fat) begin
        // bit 0 is rebuilt below so it stays one
        fat_nxt = merge(fatality_r, cfg_wdata, lanes);
      end
      if (hit_status) begin
        // zeros leave status alone, ones clear it
        status_clr = cfg_wdata & lanes & `UEMS_IMPL_MASK;
      end
    end
    fat_nxt = fat_nxt | `UEMS_FAT_FORCED;
  end

  // mask and severity flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hide_r     <= `UEMS_RST_HIDE;
      fatality_r <= `UEMS_RST_FATALITY;
    end else begin
      hide_r     <= hide_nxt;
      fatality_r <= fat_nxt;
    end
  end

  // --- read path -----------------------------------------------------
  logic [31:0] rdata_nxt;              // word returned next cycle
  logic        done_nxt;               // answer strobe

  // unmapped offsets answer zero so probing software sees nothing
  always_comb begin
    rdata_nxt = 32'h0;
    done_nxt  = cfg_rd_req | cfg_wr_req;
    if (cfg_rd_req) begin
      if (hit_status) begin
        rdata_nxt = status_r & `UEMS_IMPL_MASK;
      end else if (hit_hide) begin
        rdata_nxt = hide_r & `UEMS_IMPL_MASK;
      end else if (hit_fat) begin
        rdata_nxt = (fatality_r & `UEMS_IMPL_MASK)
                  | `UEMS_FAT_FORCED;
      end
    end
  end

  // answer register; the data bus holds zero outside a read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_r <= 32'h0;
      cfg_done_r  <= 1'b0;
    end else begin
      cfg_rdata_r <= rdata_nxt;
      cfg_done_r  <= done_nxt;
    end
  end

  // --- error reporting -----------------------------------------------
  uems_pkg::uems_msg_e msg_kind;       // message kind from reporter

  // detect pulses come from core logic on this clock, no sync
  uems_report u_report (
    .clk        (clk),
    .rst        (rst),
    .err_detect (err_detect),
    .hide       (hide_r),
    .fatality   (fatality_r),
    .status_clr (status_clr),
    .status_r   (status_r),
    .msg_kind_r (msg_kind),
    .hdr_load_r (hdr_load_r),
    .fep_load_r (fep_load_r),
    .fep_r      (fep_r)
  );

  // message strobes split out in flops so outputs stay registered
  logic msg_valid_nxt;                 // any message next cycle
  logic msg_fatal_nxt;                 // fatal flavour

  always_comb begin
    msg_valid_nxt = 1'b0;
    msg_fatal_nxt = 1'b0;
    unique case (msg_kind)
      uems_pkg::UEMS_MSG_NONE: begin
        msg_valid_nxt = 1'b0;
      end
      uems_pkg::UEMS_MSG_NONFATAL: begin
        msg_valid_nxt = 1'b1;
      end
      uems_pkg::UEMS_MSG_FATAL: begin
        msg_valid_nxt = 1'b1;
        msg_fatal_nxt = 1'b1;
      end
      default: begin
        // code 2 is never produced
        msg_valid_nxt = 1'b0;
      end
    endcase
  end

  // one extra stage: message lags status by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_valid_r <= 1'b0;
      msg_fatal_r <= 1'b0;
    end else begin
      msg_valid_r <= msg_valid_nxt;
      msg_fatal_r <= msg_fatal_nxt;
    end
  end

  // --- checks --------------------------------------------------------
  logic [31:0] live_now;               // unmasked errors this cycle
  assign live_now = err_detect & ~hide_r & `UEMS_IMPL_MASK;

  property p_masked_no_status;
    @(posedge clk) disable iff (rst)
      ((err_detect & hide_r & ~status_r) != 32'h0)
      |=> ((status_r & $past(err_detect & hide_r & ~status_r)) == 32'h0);
  endproperty
  a_masked_no_status: assert property (p_masked_no_status)
    else $error("masked error set its status bit");

  property p_masked_no_msg;
    @(posedge clk) disable iff (rst)
      (err_detect != 32'h0 && live_now == 32'h0)
      |-> ##2 !msg_valid_r;
  endproperty
  a_masked_no_msg: assert property (p_masked_no_msg)
    else $error("message sent for a masked error");

  property p_masked_no_hdr;
    @(posedge clk) disable iff (rst)
      (live_now == 32'h0) |=> !hdr_load_r;
  endproperty
  a_masked_no_hdr: assert property (p_masked_no_hdr)
    else $error("header log loaded without an unmasked error");

  property p_masked_no_fep;
    @(posedge clk) disable iff (rst)
      (live_now == 32'h0) |=> (!fep_load_r && $stable(fep_r));
  endproperty
  a_masked_no_fep: assert property (p_masked_no_fep)
    else $error("first error pointer moved without an unmasked error");

  property p_hide_write;
    @(posedge clk) disable iff (rst)
      (cfg_wr_req && hit_hide && cfg_be == 4'hf)
      |=> (hide_r == ($past(cfg_wdata) & `UEMS_IMPL_MASK));
  endproperty
  a_hide_write: assert property (p_hide_write)
    else $error("mask register write stored the wrong value");

  property p_hide_read;
    @(posedge clk) disable iff (rst)
      (cfg_rd_req && hit_hide)
      |=> (cfg_done_r && (cfg_rdata_r & ~`UEMS_IMPL_MASK) == 32'h0);
  endproperty
  a_hide_read: assert property (p_hide_read)
    else $error("mask reserved bits read nonzero");

  property p_fat_read;
    @(posedge clk) disable iff (rst)
      (cfg_rd_req && hit_fat)
      |=> (cfg_done_r
           && (cfg_rdata_r & ~`UEMS_IMPL_MASK) == `UEMS_FAT_FORCED);
  endproperty
  a_fat_read: assert property (p_fat_read)
    else $error("severity reserved bits read wrongly");

  property p_severity_type;
    @(posedge clk) disable iff (rst)
      (live_now != 32'h0)
      |-> ##2 (msg_valid_r
               && msg_fatal_r == ($past(live_now & fatality_r, 2) != 0));
  endproperty
  a_severity_type: assert property (p_severity_type)
    else $error("message kind does not follow severity");

  property p_status_set;
    @(posedge clk) disable iff (rst)
      (live_now != 32'h0)
      |=> ((status_r & $past(live_now)) == $past(live_now));
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("unmasked error did not set its status bit");

  property p_status_clear;
    @(posedge clk) disable iff (rst)
      (cfg_wr_req && hit_status && err_detect == 32'h0)
      |=> (status_r == ($past(status_r) & ~$past(status_clr)));
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status write did not clear exactly the ones");

  property p_fat_bit0;
    @(posedge clk) disable iff (rst)
      cfg_wr_req && hit_fat |=> fatality_r[0] ##1 fatality_r[0];
  endproperty
  a_fat_bit0: assert property (p_fat_bit0)
    else $error("severity bit 0 lost its one");

  // register shape and message provenance checks
  property p_fat_write;
    @(posedge clk) disable iff (rst)
      (cfg_wr_req && hit_fat && cfg_be == 4'hf)
      |=> (fatality_r
           == (($past(cfg_wdata) & `UEMS_IMPL_MASK) | `UEMS_FAT_FORCED));
  endproperty
  a_fat_write: assert property (p_fat_write)
    else $error("severity register write stored the wrong value");

  property p_hide_reserved;
    @(posedge clk) disable iff (rst)
      (hide_r & ~`UEMS_IMPL_MASK) == 32'h0;
  endproperty
  a_hide_reserved: assert property (p_hide_reserved)
    else $error("mask reserved bit holds a one");

  property p_fat_reserved;
    @(posedge clk) disable iff (rst)
      (fatality_r & ~`UEMS_IMPL_MASK) == `UEMS_FAT_FORCED;
  endproperty
  a_fat_reserved: assert property (p_fat_reserved)
    else $error("severity reserved bits hold a wrong value");

  // without a clear, a recorded error must stay recorded
  property p_status_sticky;
    @(posedge clk) disable iff (rst)
      !(cfg_wr_req && hit_status)
      |=> ((status_r & $past(status_r)) == $past(status_r));
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit dropped without a write-one clear");

  // a message two cycles on needs an unmasked error now
  property p_msg_needs_live;
    @(posedge clk) disable iff (rst)
      msg_valid_r |-> ($past(live_now, 2) != 32'h0);
  endproperty
  a_msg_needs_live: assert property (p_msg_needs_live)
    else $error("message sent with no unmasked error behind it");

  property p_status_reserved;
    @(posedge clk) disable iff (rst)
      (status_r & ~`UEMS_IMPL_MASK) == 32'h0;
  endproperty
  a_status_reserved: assert property (p_status_reserved)
    else $error("status bit set outside the error positions");
endmodule
`default_nettype wire

// File: testbench/uems_cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
// config access master standing in for the upstream link partner
module uems_cfg_host (
  input  wire logic        clk,
  input  wire logic        cfg_done_r,
  input  wire logic [31:0] cfg_rdata_r,
  output var  logic        cfg_rd_req,
  output var  logic        cfg_wr_req,
  output var  logic [11:0] cfg_addr,
  output var  logic [3:0]  cfg_be,
  output var  logic [31:0] cfg_wdata
);
  // bus idle from time zero
  initial begin
    cfg_rd_req = 1'b0;
    cfg_wr_req = 1'b0;
    cfg_addr   = 12'hfff;
    cfg_be     = 4'h0;
    cfg_wdata  = 32'h0;
  end

  // one access: request up for one sampling edge, answer taken a cycle on;
  // released lines get inverted so stale values never pass as live ones
  task automatic access(input logic wr, input logic [11:0] a,
                        input logic [3:0] be, input logic [31:0] wd,
                        output logic done, output logic [31:0] rd);
    @(negedge clk);
    cfg_rd_req = !wr;
    cfg_wr_req = wr;
    cfg_addr   = a;
    cfg_be     = be;
    cfg_wdata  = wd;
    @(negedge clk);
    done       = cfg_done_r;
    rd         = cfg_rdata_r;
    cfg_rd_req = 1'b0;
    cfg_wr_req = 1'b0;
    cfg_addr   = ~a;
    cfg_be     = ~be;
    cfg_wdata  = ~wd;
  endtask

  // status bits go away only by writing ones to them
  task automatic clear_status(input logic [31:0] bits, output logic done);
    logic [31:0] unused;
    access(1'b1, 12'h104, 4'hf, bits, done, unused);
  endtask
endmodule
`default_nettype wire

// File: testbench/uems_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the error hide and fatality registers
module uncorrectable_error_mask_severity_tb_top;
  logic        clk;         // core clock
  logic        rst;         // async reset
  logic        rd_req;      // host read request
  logic        wr_req;      // host write request
  logic [11:0] addr;        // host offset
  logic [3:0]  be;          // host byte enables
  logic [31:0] wdata;       // host write data
  logic [31:0] err_detect;  // error pulses
  logic [31:0] rdata;       // read answer
  logic        done;        // access answer
  logic [31:0] status_r;    // status word
  logic [31:0] hide_r;      // hide word
  logic [31:0] fatality_r;  // fatality word
  logic        msg_valid_r; // message pulse
  logic        msg_fatal_r; // message kind
  logic        hdr_load_r;  // header load
  logic        fep_load_r;  // pointer load
  logic [4:0]  fep_r;       // pointer value
  int          num_errors = 0;
  int          checks_done = 0;
  // every implemented error position
  int          bits [10] = '{4, 12, 13, 14, 15, 16, 17, 18, 19, 20};

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  uems_top dut_u (.clk(clk), .rst(rst), .cfg_rd_req(rd_req),
    .cfg_wr_req(wr_req), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata),
    .err_detect(err_detect), .cfg_rdata_r(rdata), .cfg_done_r(done),
    .status_r(status_r), .hide_r(hide_r), .fatality_r(fatality_r),
    .msg_valid_r(msg_valid_r), .msg_fatal_r(msg_fatal_r),
    .hdr_load_r(hdr_load_r), .fep_load_r(fep_load_r), .fep_r(fep_r));

  uems_cfg_host host_u (.clk(clk), .cfg_done_r(done), .cfg_rdata_r(rdata),
    .cfg_rd_req(rd_req), .cfg_wr_req(wr_req), .cfg_addr(addr),
    .cfg_be(be), .cfg_wdata(wdata));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and stop, shared with the watchdog
  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // write, and the access must be answered
  task automatic wr(input logic [11:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    logic        ok;
    logic [31:0] v;
    host_u.access(1'b1, a, b, d, ok, v);
    chk(32'(ok), 32'h1);
  endtask

  // read and compare the answer
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic        ok;
    logic [31:0] v;
    host_u.access(1'b0, a, 4'hf, 32'h0, ok, v);
    chk(32'(ok), 32'h1);
    chk(v, exp);
  endtask

  // one-cycle error pulse; returns where the +1 outputs have settled
  task automatic pulse(input logic [31:0] v);
    @(negedge clk);
    err_detect = v;
    @(negedge clk);
    err_detect = 32'h0;
  endtask

  // reset values on ports and through the bus
  task automatic t_reset;
    chk(hide_r, 32'h0);
    chk(fatality_r, 32'h00062011);
    rd_chk(12'h108, 32'h0);
    rd_chk(12'h10c, 32'h00062011);
    rd_chk(12'h104, 32'h0);
  endtask

  // writable, reserved and forced bits, byte lanes, unmapped place
  task automatic t_regs;
    wr(12'h108, 4'hf, 32'hffffffff);
    rd_chk(12'h108, 32'h001ff010);
    wr(12'h10c, 4'hf, 32'hffffffff);
    rd_chk(12'h10c, 32'h001ff011);
    wr(12'h10c, 4'h1, 32'h0);
    rd_chk(12'h10c, 32'h001ff001);
    wr(12'h10c, 4'hf, 32'h0);
    rd_chk(12'h10c, 32'h00000001);
    wr(12'h200, 4'hf, 32'hffffffff);
    rd_chk(12'h200, 32'h0);
    wr(12'h108, 4'hf, 32'h0);
    rd_chk(12'h108, 32'h0);
  endtask

  // each error alone: status, loads, pointer, message kind, clearing
  task automatic t_report(input logic [31:0] sev);
    logic ok;
    wr(12'h10c, 4'hf, sev);
    for (int i = 0; i < 10; i++) begin
      pulse(32'h1 << bits[i]);
      chk(status_r, 32'h1 << bits[i]);
      chk({hdr_load_r, fep_load_r, fep_r}, {2'b11, 5'(bits[i])});
      @(negedge clk);
      chk({msg_valid_r, msg_fatal_r}, {1'b1, sev[bits[i]]});
      wr(12'h104, 4'hf, 32'h0);
      chk({msg_valid_r, hdr_load_r, fep_load_r}, 3'b000);
      chk(status_r, 32'h1 << bits[i]);
      host_u.clear_status(32'h1 << bits[i], ok);
      chk(status_r, 32'h0);
    end
  endtask

  // one position hidden, then all hidden
  task automatic t_masked;
    logic ok;
    // hidden bit 12 is fatal, live bit 18 nonfatal: a leak shows as fatal
    wr(12'h108, 4'hf, 32'h00001000);
    pulse(32'h00041000);
    chk(status_r, 32'h00040000);
    chk(32'(fep_r), 32'd18);
    @(negedge clk);
    chk({msg_valid_r, msg_fatal_r}, 2'b10);
    host_u.clear_status(32'h00040000, ok);
    wr(12'h108, 4'hf, 32'hffffffff);
    pulse(32'h001ff010);
    chk(status_r, 32'h0);
    chk(32'(hdr_load_r), 32'h0);
    chk({fep_load_r, fep_r}, {1'b0, 5'd18});
    @(negedge clk);
    chk(32'(msg_valid_r), 32'h0);
  endtask

  // reset again in mid-run: everything returns to its default
  task automatic t_rerst;
    wr(12'h108, 4'hf, 32'h00100010);
    pulse(32'h00001000);
    rst = 1'b1;
    @(negedge clk);
    chk(hide_r, 32'h0);
    chk(fatality_r, 32'h00062011);
    chk(status_r, 32'h0);
    @(negedge clk);
    rst = 1'b0;
    rd_chk(12'h10c, 32'h00062011);
    rd_chk(12'h108, 32'h0);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    err_detect = 32'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_report(32'h00062011);
    t_report(32'h0019d000);
    t_masked();
    t_rerst();
    end_sim();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #50000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
